// file: hw/shd_pkg.sv
// Package: types and constants of the shared memory home directory
package shd_pkg;
    localparam int ID_W = 8;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam int ENTRIES = 4;
    localparam int ENT_W = 2;
    localparam int GRAN_W = 4;
    localparam int GRANULES = 16;
    localparam int OP_W = 4;
    localparam int DIR_W = 2;
    localparam int LRESP_W = 2;
    // Packet kinds, requests and responses share one code space
    localparam logic [OP_W-1:0] OP_NONE = 4'h0;
    localparam logic [OP_W-1:0] OP_IO_READ_HOME = 4'h1;
    localparam logic [OP_W-1:0] OP_IO_READ_OWNER = 4'h2;
    localparam logic [OP_W-1:0] OP_READ_HOME = 4'h3;
    localparam logic [OP_W-1:0] OP_READ_OWNER = 4'h4;
    localparam logic [OP_W-1:0] OP_DONE = 4'h8;
    localparam logic [OP_W-1:0] OP_DONE_INTERVENTION = 4'h9;
    localparam logic [OP_W-1:0] OP_DATA_ONLY = 4'hA;
    localparam logic [OP_W-1:0] OP_INTERVENTION = 4'hB;
    localparam logic [OP_W-1:0] OP_NOT_OWNER = 4'hC;
    localparam logic [OP_W-1:0] OP_RETRY = 4'hD;
    // Directory states
    localparam logic [DIR_W-1:0] DIR_LOCAL_MODIFIED = 2'h0;
    localparam logic [DIR_W-1:0] DIR_LOCAL_SHARED = 2'h1;
    localparam logic [DIR_W-1:0] DIR_SHARED = 2'h2;
    localparam logic [DIR_W-1:0] DIR_REMOTE_MODIFIED = 2'h3;
    // Local cache answers
    localparam logic [LRESP_W-1:0] LRESP_PENDING = 2'h0;
    localparam logic [LRESP_W-1:0] LRESP_MODIFIED = 2'h1;
    localparam logic [LRESP_W-1:0] LRESP_INVALID = 2'h2;
    // Error causes
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_BAD_OP = 3'h1;
    localparam logic [2:0] ERR_BAD_RESP = 3'h2;
    localparam logic [2:0] ERR_PARADOX = 3'h3;
    localparam logic [2:0] ERR_BAD_LRESP = 3'h4;
    localparam logic [2:0] ERR_BAD_DIR = 3'h5;
    localparam logic [ID_W-1:0] OWN_ID_DEFAULT = 8'h01;
    // Directory map loaded by reset: dirty-local and remote-owned granules
    localparam logic [GRANULES-1:0] RST_LOCAL_DIRTY = 16'h000F;
    localparam logic [GRANULES-1:0] RST_REMOTE_OWNED = 16'hF000;
    localparam logic [ID_W-1:0] RST_OWNER_ID = 8'h20;
    typedef enum logic [5:0] {
        SHD_IDLE = 6'b000001,
        SHD_LOCAL = 6'b000010,
        SHD_SEND1 = 6'b000100,
        SHD_SEND2 = 6'b001000,
        SHD_WAIT_OWNER = 6'b010000,
        SHD_OWNER_ASK = 6'b100000
    } shd_state_type;
endpackage

// file: hw/shd_home.sv
// Home directory for coherent and I/O reads; owner logic for I/O reads only
`timescale 1ns/10ps
module shd_home
    import shd_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [shd_pkg::ID_W-1:0] OWN_IDENTIFIER,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [shd_pkg::OP_W-1:0] IN_OP,
    input wire logic [shd_pkg::ID_W-1:0] IN_SRC,
    input wire logic [shd_pkg::ID_W-1:0] IN_SEC,
    input wire logic [shd_pkg::GRAN_W-1:0] IN_GRAN,
    input wire logic [shd_pkg::DATA_W-1:0] IN_DATA,
    input wire logic IN_COLLIDE,
    output logic COLL_VALID,
    output logic [shd_pkg::OP_W-1:0] COLL_OP,
    output logic [shd_pkg::ID_W-1:0] COLL_SRC,
    output logic [shd_pkg::GRAN_W-1:0] COLL_GRAN,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [shd_pkg::OP_W-1:0] OUT_OP,
    output logic [shd_pkg::ID_W-1:0] OUT_DEST,
    output logic [shd_pkg::ID_W-1:0] OUT_SEC,
    output logic OUT_HAS_DATA,
    output logic [shd_pkg::DATA_W-1:0] OUT_DATA,
    output logic LOC_REQ,
    input wire logic LOC_DONE,
    input wire logic [shd_pkg::LRESP_W-1:0] LOC_RESP,
    input wire logic [shd_pkg::DATA_W-1:0] LOC_DATA,
    output logic ERR_PULSE,
    output logic [2:0] ERR_CODE
);
    import shd_pkg::*;

    // ------------------------------------------------------------
    // Directory, memory and entry table
    // ------------------------------------------------------------
    logic [DIR_W-1:0] dir_state [GRANULES];
    logic [ID_W-1:0] dir_owner [GRANULES];
    logic [DATA_W-1:0] mem [GRANULES];
    logic [ENTRIES-1:0] ent_busy;
    logic [OP_W-1:0] ent_op [ENTRIES];
    logic [ID_W-1:0] ent_src [ENTRIES];
    logic [ID_W-1:0] ent_sec [ENTRIES];
    logic [GRAN_W-1:0] ent_gran [ENTRIES];
    shd_state_type state;
    logic [ENT_W-1:0] cur;
    logic [OP_W-1:0] op2;
    logic [ID_W-1:0] dest2;
    logic [DATA_W-1:0] data2;
    logic has2;
    logic [ENT_W-1:0] free_idx;
    logic free_any;
    logic is_req;
    logic is_resp;
    logic [ENT_W-1:0] match_idx;
    logic match_any;

    always_comb begin
        free_idx = '0;
        free_any = 1'b0;
        match_idx = '0;
        match_any = 1'b0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (!ent_busy[i]) begin
                free_idx = ENT_W'(i);
                free_any = 1'b1;
            end
            if (ent_busy[i] && ent_gran[i] == IN_GRAN && ent_op[i] != OP_IO_READ_OWNER) begin
                match_idx = ENT_W'(i);
                match_any = 1'b1;
            end
        end
    end

    // A coherent read to the owner (OP_READ_OWNER) is never taken as a request here
    assign is_req = IN_OP == OP_IO_READ_HOME || IN_OP == OP_IO_READ_OWNER
        || IN_OP == OP_READ_HOME;
    assign is_resp = IN_OP == OP_INTERVENTION || IN_OP == OP_NOT_OWNER || IN_OP == OP_RETRY;
    // Requests wait for a free entry; collisions and responses pass freely
    assign IN_READY = state == SHD_IDLE && (IN_COLLIDE || !is_req || free_any);

    logic take;
    assign take = IN_VALID && IN_READY;

    // ------------------------------------------------------------
    // Collision hand-off
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            COLL_VALID <= 1'b0;
            COLL_OP <= OP_NONE;
            COLL_SRC <= '0;
            COLL_GRAN <= '0;
        end else begin
            COLL_VALID <= take && IN_COLLIDE;
            COLL_OP <= IN_OP;
            COLL_SRC <= IN_SRC;
            COLL_GRAN <= IN_GRAN;
        end
    end

    assign LOC_REQ = state == SHD_LOCAL || state == SHD_OWNER_ASK;

    // ------------------------------------------------------------
    // Main sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state <= SHD_IDLE;
            cur <= '0;
            ent_busy <= '0;
            OUT_VALID <= 1'b0;
            OUT_OP <= OP_NONE;
            OUT_DEST <= '0;
            OUT_SEC <= '0;
            OUT_HAS_DATA <= 1'b0;
            OUT_DATA <= '0;
            op2 <= OP_NONE;
            dest2 <= '0;
            data2 <= '0;
            has2 <= 1'b0;
            ERR_PULSE <= 1'b0;
            ERR_CODE <= ERR_NONE;
            // Fixed map so every directory state is reachable after reset
            for (int g = 0; g < GRANULES; g++) begin
                dir_state[g] <= RST_REMOTE_OWNED[g] ? DIR_REMOTE_MODIFIED
                    : RST_LOCAL_DIRTY[g] ? DIR_LOCAL_MODIFIED : DIR_LOCAL_SHARED;
                dir_owner[g] <= RST_REMOTE_OWNED[g] ? RST_OWNER_ID : '0;
                mem[g] <= '0;
            end
            for (int e = 0; e < ENTRIES; e++) begin
                ent_op[e] <= OP_NONE;
                ent_src[e] <= '0;
                ent_sec[e] <= '0;
                ent_gran[e] <= '0;
            end
        end else begin
            ERR_PULSE <= 1'b0;
            if (OUT_VALID && OUT_READY) begin
                OUT_VALID <= 1'b0;
            end
            case (state)
                SHD_IDLE: begin
                    if (take && !IN_COLLIDE && is_req) begin
                        cur <= free_idx;
                        ent_busy[free_idx] <= 1'b1;
                        ent_op[free_idx] <= IN_OP;
                        ent_src[free_idx] <= IN_SRC;
                        ent_sec[free_idx] <= IN_SEC;
                        ent_gran[free_idx] <= IN_GRAN;
                        OUT_SEC <= '0;
                        OUT_DATA <= mem[IN_GRAN];
                        OUT_DEST <= IN_SRC;
                        if (IN_OP == OP_IO_READ_OWNER) begin
                            state <= SHD_OWNER_ASK;
                        end else begin
                            case (dir_state[IN_GRAN])
                                DIR_LOCAL_MODIFIED: begin
                                    state <= SHD_LOCAL;
                                end
                                DIR_LOCAL_SHARED, DIR_SHARED: begin
                                    if (IN_OP == OP_READ_HOME) begin
                                        dir_state[IN_GRAN] <= DIR_SHARED;
                                    end
                                    OUT_VALID <= 1'b1;
                                    OUT_OP <= OP_DONE;
                                    OUT_HAS_DATA <= 1'b1;
                                    ent_busy[free_idx] <= 1'b0;
                                    state <= SHD_SEND1;
                                    has2 <= 1'b0;
                                end
                                default: begin
                                    if (IN_OP == OP_READ_HOME && dir_owner[IN_GRAN] == IN_SRC) begin
                                        ERR_PULSE <= 1'b1;
                                        ERR_CODE <= ERR_PARADOX;
                                        ent_busy[free_idx] <= 1'b0;
                                    end else begin
                                        OUT_VALID <= 1'b1;
                                        OUT_OP <= IN_OP == OP_READ_HOME ? OP_READ_OWNER
                                            : OP_IO_READ_OWNER;
                                        OUT_DEST <= dir_owner[IN_GRAN];
                                        OUT_SEC <= IN_SRC;
                                        OUT_HAS_DATA <= 1'b0;
                                        has2 <= 1'b0;
                                        state <= SHD_SEND1;
                                    end
                                end
                            endcase
                        end
                    end else if (take && !IN_COLLIDE && is_resp) begin
                        if (!match_any) begin
                            ERR_PULSE <= 1'b1;
                            ERR_CODE <= ERR_BAD_RESP;
                        end else begin
                            cur <= match_idx;
                            OUT_VALID <= 1'b1;
                            OUT_SEC <= '0;
                            state <= SHD_SEND1;
                            if (IN_OP == OP_INTERVENTION) begin
                                mem[IN_GRAN] <= IN_DATA;
                                if (ent_op[match_idx] == OP_READ_HOME) begin
                                    dir_state[IN_GRAN] <= DIR_SHARED;
                                end else begin
                                    dir_state[IN_GRAN] <= DIR_LOCAL_SHARED;
                                end
                                OUT_OP <= OP_DONE_INTERVENTION;
                                OUT_DEST <= ent_src[match_idx];
                                OUT_HAS_DATA <= 1'b0;
                                has2 <= 1'b0;
                                ent_busy[match_idx] <= 1'b0;
                            end else if (dir_state[IN_GRAN] == DIR_REMOTE_MODIFIED) begin
                                OUT_OP <= ent_op[match_idx] == OP_READ_HOME ? OP_READ_OWNER
                                    : OP_IO_READ_OWNER;
                                OUT_DEST <= IN_SRC;
                                OUT_SEC <= OWN_IDENTIFIER;
                                OUT_HAS_DATA <= 1'b0;
                                has2 <= 1'b0;
                            end else begin
                                if (ent_op[match_idx] == OP_READ_HOME) begin
                                    dir_state[IN_GRAN] <= DIR_SHARED;
                                end
                                OUT_OP <= OP_DATA_ONLY;
                                OUT_DEST <= ent_src[match_idx];
                                OUT_HAS_DATA <= 1'b1;
                                OUT_DATA <= mem[IN_GRAN];
                                has2 <= 1'b1;
                                op2 <= OP_DONE_INTERVENTION;
                                dest2 <= ent_src[match_idx];
                                ent_busy[match_idx] <= 1'b0;
                            end
                        end
                    end else if (take && !IN_COLLIDE && IN_OP != OP_NONE) begin
                        ERR_PULSE <= 1'b1;
                        ERR_CODE <= ERR_BAD_OP;
                    end
                end
                SHD_LOCAL: begin
                    if (LOC_DONE) begin
                        // Push has landed; memory now holds the newest copy
                        mem[ent_gran[cur]] <= LOC_DATA;
                        OUT_DATA <= LOC_DATA;
                        if (ent_op[cur] == OP_READ_HOME) begin
                            dir_state[ent_gran[cur]] <= DIR_SHARED;
                        end
                        OUT_VALID <= 1'b1;
                        OUT_OP <= OP_DONE;
                        OUT_HAS_DATA <= 1'b1;
                        has2 <= 1'b0;
                        ent_busy[cur] <= 1'b0;
                        state <= SHD_SEND1;
                    end
                end
                SHD_OWNER_ASK: begin
                    if (LOC_DONE && LOC_RESP != LRESP_PENDING) begin
                        OUT_VALID <= 1'b1;
                        OUT_SEC <= '0;
                        ent_busy[cur] <= 1'b0;
                        state <= SHD_SEND1;
                        OUT_DEST <= ent_src[cur];
                        OUT_DATA <= LOC_DATA;
                        has2 <= 1'b0;
                        if (LOC_RESP == LRESP_MODIFIED && ent_sec[cur] == ent_src[cur]) begin
                            OUT_OP <= OP_INTERVENTION;
                            OUT_HAS_DATA <= 1'b1;
                        end else if (LOC_RESP == LRESP_MODIFIED) begin
                            OUT_OP <= OP_DATA_ONLY;
                            OUT_DEST <= ent_sec[cur];
                            OUT_HAS_DATA <= 1'b1;
                            has2 <= 1'b1;
                            op2 <= OP_INTERVENTION;
                            dest2 <= ent_src[cur];
                        end else if (LOC_RESP == LRESP_INVALID) begin
                            OUT_OP <= OP_NOT_OWNER;
                            OUT_HAS_DATA <= 1'b0;
                        end else begin
                            OUT_VALID <= 1'b0;
                            ERR_PULSE <= 1'b1;
                            ERR_CODE <= ERR_BAD_LRESP;
                            state <= SHD_IDLE;
                        end
                    end
                end
                SHD_SEND1: begin
                    if (OUT_READY) begin
                        if (has2) begin
                            OUT_VALID <= 1'b1;
                            OUT_OP <= op2;
                            OUT_DEST <= dest2;
                            OUT_HAS_DATA <= 1'b0;
                            state <= SHD_SEND2;
                        end else begin
                            state <= SHD_IDLE;
                        end
                    end
                end
                SHD_SEND2: begin
                    if (OUT_READY) begin
                        state <= SHD_IDLE;
                    end
                end
                default: begin
                    state <= SHD_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_local_done_answer: assert property (@(posedge CLK) disable iff (!RESETN)
        state == SHD_LOCAL && LOC_DONE |=> OUT_VALID && OUT_OP == OP_DONE && OUT_HAS_DATA)
        else $error("local read did not answer with DONE and data");
    a_owner_invalid: assert property (@(posedge CLK) disable iff (!RESETN)
        state == SHD_OWNER_ASK && LOC_DONE && LOC_RESP == LRESP_INVALID
        |=> OUT_OP == OP_NOT_OWNER && !ent_busy[$past(cur)])
        else $error("invalid cache answer did not give NOT_OWNER");
    a_split_second: assert property (@(posedge CLK) disable iff (!RESETN)
        state == SHD_SEND1 && has2 && OUT_OP == OP_DATA_ONLY && OUT_READY
        |=> OUT_VALID && state == SHD_SEND2)
        else $error("second packet missing after DATA_ONLY");
    a_no_full_take: assert property (@(posedge CLK) disable iff (!RESETN)
        &ent_busy && IN_VALID && is_req && !IN_COLLIDE |-> !IN_READY)
        else $error("request taken with no free entry");
    a_collide_pass: assert property (@(posedge CLK) disable iff (!RESETN)
        take && IN_COLLIDE |=> COLL_VALID && state == SHD_IDLE)
        else $error("colliding request not handed off");
    a_paradox_flag: assert property (@(posedge CLK) disable iff (!RESETN)
        take && !IN_COLLIDE && IN_OP == OP_READ_HOME
        && dir_state[IN_GRAN] == DIR_REMOTE_MODIFIED && dir_owner[IN_GRAN] == IN_SRC
        |=> ERR_PULSE && ERR_CODE == ERR_PARADOX)
        else $error("cache paradox not flagged");
    a_interv_write: assert property (@(posedge CLK) disable iff (!RESETN)
        take && !IN_COLLIDE && IN_OP == OP_INTERVENTION && match_any
        |=> OUT_OP == OP_DONE_INTERVENTION ##0 mem[$past(IN_GRAN)] == $past(IN_DATA))
        else $error("intervention did not update memory");
    a_unknown_resp: assert property (@(posedge CLK) disable iff (!RESETN)
        take && !IN_COLLIDE && is_resp && !match_any |=> ERR_PULSE)
        else $error("stray response not reported");
endmodule

// file: bench/shd_peer.sv
// Peer model: local caches answering owner lookups and a stalling packet sink
`timescale 1ns/10ps
module shd_peer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic loc_req,
    output logic loc_done,
    output logic [shd_pkg::LRESP_W-1:0] loc_resp,
    output logic [shd_pkg::DATA_W-1:0] loc_data,
    output logic out_ready,
    input wire logic [shd_pkg::LRESP_W-1:0] resp_sel,
    input wire logic pend_first,
    input wire logic [shd_pkg::DATA_W-1:0] line
);
    import shd_pkg::*;
    int seed = 32'h8291;
    int cnt = 0;
    logic asked = 0;
    // Data lines toggle outside an answer so stale values never look valid
    always @(posedge clk) begin
        loc_done <= 0;
        loc_data <= ~loc_data;
        loc_resp <= ~loc_resp;
        out_ready <= ($random(seed) & 3) != 0;
        if (!resetn) begin
            cnt <= 0;
            asked <= 0;
            loc_resp <= 0;
            loc_data <= 0;
        end else if (loc_req && !loc_done) begin
            if (cnt == 0) cnt <= 1 + {$random(seed)} % 3;
            else if (cnt == 1) begin
                loc_done <= 1;
                loc_resp <= (pend_first && !asked) ? LRESP_PENDING : resp_sel;
                loc_data <= line;
                asked <= 1;
                cnt <= 0;
            end else cnt <= cnt - 1;
        end else if (!loc_req) asked <= 0;
    end
endmodule

// file: bench/shd_home_bench.sv
// Self-checking bench of the home directory with a peer model
`timescale 1ns/10ps
module shd_home_bench;
    import shd_pkg::*;
    logic clk = 0, resetn = 0, in_valid = 0, in_collide = 0, pend_first = 0;
    logic loc_done, out_ready, loc_req, in_ready, coll_valid, out_valid, out_has_data, err_pulse;
    logic [OP_W-1:0] in_op = 0, coll_op, out_op;
    logic [ID_W-1:0] in_src = 0, in_sec = 0, coll_src, out_dest, out_sec, s, c, got_sec;
    logic [GRAN_W-1:0] in_gran = 0, coll_gran;
    logic [DATA_W-1:0] in_data = 0, out_data, loc_data, line = 0, exp_data;
    logic [LRESP_W-1:0] loc_resp, resp_sel = 0;
    logic [2:0] err_code, last_err;
    logic [15:0] lc;
    logic [84:0] pq[$];
    logic [84:0] p;
    int bad_count = 0, total_checks = 0, coll_n = 0, err_n = 0, i;
    int seed = 32'h8291;
    always #20 clk = ~clk;
    shd_home uut (.CLK(clk), .RESETN(resetn), .OWN_IDENTIFIER(OWN_ID_DEFAULT),
        .IN_VALID(in_valid), .IN_READY(in_ready), .IN_OP(in_op), .IN_SRC(in_src),
        .IN_SEC(in_sec), .IN_GRAN(in_gran), .IN_DATA(in_data), .IN_COLLIDE(in_collide),
        .COLL_VALID(coll_valid), .COLL_OP(coll_op), .COLL_SRC(coll_src),
        .COLL_GRAN(coll_gran), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_OP(out_op), .OUT_DEST(out_dest), .OUT_SEC(out_sec),
        .OUT_HAS_DATA(out_has_data), .OUT_DATA(out_data), .LOC_REQ(loc_req),
        .LOC_DONE(loc_done), .LOC_RESP(loc_resp), .LOC_DATA(loc_data),
        .ERR_PULSE(err_pulse), .ERR_CODE(err_code));
    shd_peer peer (.clk(clk), .resetn(resetn), .loc_req(loc_req), .loc_done(loc_done),
        .loc_resp(loc_resp), .loc_data(loc_data), .out_ready(out_ready),
        .resp_sel(resp_sel), .pend_first(pend_first), .line(line));
    always @(posedge clk) begin
        if (out_valid === 1'b1 && out_ready)
            pq.push_back({out_sec, out_op, out_dest, out_has_data, out_data});
        if (coll_valid === 1'b1) begin
            coll_n++;
            lc = {coll_op, coll_src, coll_gran};
        end
        if (err_pulse === 1'b1) begin
            err_n++;
            last_err = err_code;
        end
    end
    task report_and_stop;
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task fail(string m);
        bad_count++;
        $display("ERROR %0t %s", $time, m);
    endtask
    task send(logic [OP_W-1:0] op, logic [ID_W-1:0] src, logic [ID_W-1:0] sec,
              logic [GRAN_W-1:0] g, logic col);
        int n;
        n = 0;
        in_valid <= 1;
        in_op <= op;
        in_src <= src;
        in_sec <= sec;
        in_gran <= g;
        in_collide <= col;
        in_data <= {$random(seed), $random(seed)};
        do begin
            @(negedge clk);
            n++;
        end while (in_ready !== 1'b1 && n < 200);
        if (in_ready !== 1'b1) fail("request not taken");
        @(posedge clk);
        in_valid <= 0;
        in_collide <= 0;
    endtask
    task cmp_pkt(logic [OP_W-1:0] op, logic [ID_W-1:0] d, logic hd, logic [DATA_W-1:0] dat);
        int n;
        n = 0;
        while (pq.size() == 0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        total_checks++;
        if (pq.size() == 0) fail("no packet");
        else begin
            p = pq.pop_front();
            got_sec = p[84:77];
            if (p[76:65] !== {op, d} || p[64] !== hd || (hd && p[63:0] !== dat)) fail("packet");
        end
    endtask
    task cmp_val(logic [31:0] got, logic [31:0] exp, string m);
        total_checks++;
        if (got !== exp) fail(m);
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        report_and_stop;
    end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1;
        // ----------------------------------------
        // Reads of shared states answer from zeroed memory
        // ----------------------------------------
        for (i = 0; i < 12; i++) begin
            s = $random(seed);
            send(i[0] ? OP_IO_READ_HOME : OP_READ_HOME, s, 0,
                 (i < 4) ? 4'h5 : 4'h4 + 4'($random(seed) & 7), 0);
            cmp_pkt(OP_DONE, s, 1, 0);
        end
        // Owner lookups: modified to home, modified to third party, invalid
        for (i = 0; i < 6; i++) begin
            resp_sel <= (i % 3 == 2) ? LRESP_INVALID : LRESP_MODIFIED;
            pend_first <= (i >= 3);
            line <= {$random(seed), $random(seed)};
            s = $random(seed);
            c = (i % 3 == 0) ? s : s ^ 8'h80;
            send(OP_IO_READ_OWNER, s, c, $random(seed), 0);
            if (i % 3 == 2) cmp_pkt(OP_NOT_OWNER, s, 0, 0);
            else if (i % 3 == 0) cmp_pkt(OP_INTERVENTION, s, 1, line);
            else begin
                cmp_pkt(OP_DATA_ONLY, c, 1, line);
                cmp_pkt(OP_INTERVENTION, s, 0, 0);
            end
        end
        send(OP_READ_HOME, 8'h33, 0, 4'h9, 1);
        repeat (3) @(posedge clk);
        cmp_val(coll_n, 1, "collision count");
        cmp_val(lc, {OP_READ_HOME, 8'h33, 4'h9}, "collision fields");
        cmp_val(pq.size(), 0, "stray packet");
        send(4'h7, 8'h44, 0, 4'h2, 0);
        repeat (3) @(posedge clk);
        cmp_val(err_n, 1, "error count");
        cmp_val(last_err, ERR_BAD_OP, "error code");
        send(OP_INTERVENTION, 8'h45, 0, 4'h3, 0);
        repeat (3) @(posedge clk);
        cmp_val(err_n, 2, "orphan response");
        send(OP_READ_HOME, 8'h46, 0, 4'h9, 0);
        cmp_pkt(OP_DONE, 8'h46, 1, 0);
        // ----------------------------------------
        // Dirty-local granule: push lands, then memory answers
        // ----------------------------------------
        pend_first <= 0;
        line <= {$random(seed), $random(seed)};
        send(OP_IO_READ_HOME, 8'h61, 0, 4'h1, 0);
        cmp_pkt(OP_DONE, 8'h61, 1, line);
        line <= {$random(seed), $random(seed)};
        send(OP_READ_HOME, 8'h62, 0, 4'h1, 0);
        cmp_pkt(OP_DONE, 8'h62, 1, line);
        send(OP_IO_READ_HOME, 8'h63, 0, 4'h1, 0);
        cmp_pkt(OP_DONE, 8'h63, 1, line);
        // ----------------------------------------
        // Remote-owned granules: forward, reissue, intervention
        // ----------------------------------------
        send(OP_IO_READ_HOME, 8'h61, 0, 4'hD, 0);
        cmp_pkt(OP_IO_READ_OWNER, RST_OWNER_ID, 0, 0);
        cmp_val(got_sec, 8'h61, "forward secondary");
        send(OP_RETRY, RST_OWNER_ID, 0, 4'hD, 0);
        cmp_pkt(OP_IO_READ_OWNER, RST_OWNER_ID, 0, 0);
        cmp_val(got_sec, OWN_ID_DEFAULT, "reissue secondary");
        send(OP_INTERVENTION, RST_OWNER_ID, 0, 4'hD, 0);
        exp_data = in_data;
        cmp_pkt(OP_DONE_INTERVENTION, 8'h61, 0, 0);
        send(OP_IO_READ_HOME, 8'h64, 0, 4'hD, 0);
        cmp_pkt(OP_DONE, 8'h64, 1, exp_data);
        send(OP_READ_HOME, 8'h62, 0, 4'hE, 0);
        cmp_pkt(OP_READ_OWNER, RST_OWNER_ID, 0, 0);
        cmp_val(got_sec, 8'h62, "read secondary");
        send(OP_NOT_OWNER, RST_OWNER_ID, 0, 4'hE, 0);
        cmp_pkt(OP_READ_OWNER, RST_OWNER_ID, 0, 0);
        cmp_val(got_sec, OWN_ID_DEFAULT, "coherent reissue secondary");
        send(OP_INTERVENTION, RST_OWNER_ID, 0, 4'hE, 0);
        exp_data = in_data;
        cmp_pkt(OP_DONE_INTERVENTION, 8'h62, 0, 0);
        send(OP_READ_HOME, 8'h65, 0, 4'hE, 0);
        cmp_pkt(OP_DONE, 8'h65, 1, exp_data);
        send(OP_READ_HOME, RST_OWNER_ID, 0, 4'hC, 0);
        repeat (3) @(posedge clk);
        cmp_val(err_n, 3, "paradox count");
        cmp_val(last_err, ERR_PARADOX, "paradox code");
        cmp_val(pq.size(), 0, "paradox packet");
        report_and_stop;
    end
endmodule
